// [core/phv_fifo.sv]
`timescale 1ns/100ps
module phv_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // streams
    phv_stream_if.snk push,
    phv_stream_if.src pop
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("phv_fifo: depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic do_wr, do_rd;

    assign push.ready = (cnt_q != (AW+1)'(DEPTH));
    assign pop.valid = (cnt_q != '0);
    assign pop.data = mem_q[rd_q];

    // ==========================================
    // pointers
    always_comb begin
        do_wr = ce && push.valid && push.ready;
        do_rd = ce && pop.valid && pop.ready;
        wr_d = do_wr ? wr_q + 1'b1 : wr_q;
        rd_d = do_rd ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wr_q] <= push.data;
        end
    end
endmodule // phv_fifo

// [core/phv_playback_path.sv]
`timescale 1ns/100ps
module phv_playback_path
    import phv_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // pcm samples from the tdm port
    input wire logic pcm_valid,
    output logic pcm_ready,
    input wire logic [SAMPLE_W-1:0] pcm_data,
    // decimated pdm samples
    input wire logic pdm_valid,
    output logic pdm_ready,
    input wire logic [SAMPLE_W-1:0] pdm_data,
    // processed samples to the modulator
    output logic out_valid,
    input wire logic out_ready,
    output logic [SAMPLE_W-1:0] out_data,
    // filter settings
    input wire logic [2:0] highpass_corner_sel,
    input wire logic coef_direct_en,
    input wire logic [COEF_W-1:0] coef_b0,
    input wire logic [COEF_W-1:0] coef_b1,
    input wire logic [COEF_W-1:0] coef_b2,
    input wire logic [COEF_W-1:0] coef_a1,
    input wire logic [COEF_W-1:0] coef_a2,
    // volume and level settings
    input wire logic [7:0] pcm_volume_code,
    input wire logic [7:0] pdm_volume_code,
    input wire logic [1:0] ramp_rate_sel,
    input wire logic playback_source_sel,
    input wire logic [4:0] amp_level_code,
    // status
    output logic [4:0] amp_level,
    output logic [7:0] applied_atten,
    output logic path_muted
);

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("phv_playback_path: fifo depth too small");
        end
    end

    localparam int ACC_W = 64;

    phv_stream_if #(.WIDTH(SAMPLE_W)) proc_s ();
    phv_stream_if #(.WIDTH(SAMPLE_W)) out_s ();

    // ==========================================
    // source selection
    logic sel_pdm;
    logic take;
    logic [SAMPLE_W-1:0] in_sample;
    logic [7:0] vol_code;

    always_comb begin
        sel_pdm = (playback_source_sel != SRC_PCM);
        pcm_ready = proc_s.ready && !sel_pdm;
        pdm_ready = proc_s.ready && sel_pdm;
        take = ce && (sel_pdm ? pdm_valid && pdm_ready : pcm_valid && pcm_ready);
        in_sample = sel_pdm ? pdm_data : pcm_data;
        vol_code = sel_pdm ? pdm_volume_code : pcm_volume_code;
    end

    // ==========================================
    // high-pass biquad
    logic filt_on;
    phv_coef_type coef;
    logic signed [SAMPLE_W-1:0] x1_q, x1_d, x2_q, x2_d, y1_q, y1_d, y2_q, y2_d;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] acc_sh;
    logic signed [SAMPLE_W-1:0] filt_y;
    logic signed [SAMPLE_W-1:0] hp_out;

    always_comb begin
        // reserved corner code falls back to bypass
        filt_on = !sel_pdm && (coef_direct_en ||
                  (highpass_corner_sel != CORNER_BYPASS && highpass_corner_sel != CORNER_RESERVED));
        coef = phv_preset(highpass_corner_sel);
        if (coef_direct_en) begin
            coef.b0 = coef_b0;
            coef.b1 = coef_b1;
            coef.b2 = coef_b2;
            coef.a1 = coef_a1;
            coef.a2 = coef_a2;
        end
        acc = ACC_W'($signed(in_sample) * coef.b0) + ACC_W'(x1_q * coef.b1) + ACC_W'(x2_q * coef.b2)
            - ACC_W'(y1_q * coef.a1) - ACC_W'(y2_q * coef.a2);
        acc_sh = acc >>> COEF_FRAC;
        if (acc_sh > ACC_W'(32767)) begin
            filt_y = 16'sh7fff;
        end else if (acc_sh < -ACC_W'(32768)) begin
            filt_y = -16'sh8000;
        end else begin
            filt_y = acc_sh[SAMPLE_W-1:0];
        end
        hp_out = filt_on ? filt_y : $signed(in_sample);
        x1_d = x1_q;
        x2_d = x2_q;
        y1_d = y1_q;
        y2_d = y2_q;
        if (!filt_on) begin
            // clean history so re-enabling starts without a step
            x1_d = '0;
            x2_d = '0;
            y1_d = '0;
            y2_d = '0;
        end else if (take) begin
            x1_d = $signed(in_sample);
            x2_d = x1_q;
            y1_d = filt_y;
            y2_d = y1_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            x1_q <= '0;
            x2_q <= '0;
            y1_q <= '0;
            y2_q <= '0;
        end else if (ce) begin
            x1_q <= x1_d;
            x2_q <= x2_d;
            y1_q <= y1_d;
            y2_q <= y2_d;
        end
    end

    // ==========================================
    // volume ramp
    logic [7:0] att_q, att_d, target;
    logic [3:0] cnt_q, cnt_d, period;

    always_comb begin
        target = (vol_code > VOL_MAX) ? ATT_MUTE : vol_code;
        unique case (ramp_rate_sel)
            RAMP_EVERY_1: period = RAMP_PERIOD_1;
            RAMP_EVERY_4: period = RAMP_PERIOD_4;
            RAMP_EVERY_8: period = RAMP_PERIOD_8;
            RAMP_OFF: period = RAMP_PERIOD_1;
        endcase
        att_d = att_q;
        cnt_d = cnt_q;
        if (ramp_rate_sel == RAMP_OFF) begin
            att_d = target;
            cnt_d = '0;
        end else if (att_q == target) begin
            cnt_d = '0;
        end else if (take) begin
            if (cnt_q + 4'h1 >= period) begin
                cnt_d = '0;
                att_d = (att_q < target) ? att_q + 8'h01 : att_q - 8'h01;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            att_q <= VOL_RST;
            cnt_q <= '0;
        end else if (ce) begin
            att_q <= att_d;
            cnt_q <= cnt_d;
        end
    end

    // ==========================================
    // gain and output level
    logic signed [SAMPLE_W+GAIN_FRAC+1:0] prod;
    logic [4:0] lvl_q, lvl_d;

    always_comb begin
        prod = hp_out * $signed({1'b0, phv_gain(att_q)});
        proc_s.valid = take;
        proc_s.data = prod[SAMPLE_W+GAIN_FRAC-1:GAIN_FRAC];
        // reserved level codes leave the setting unchanged
        lvl_d = (amp_level_code <= AMP_LEVEL_MAX) ? amp_level_code : lvl_q;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lvl_q <= AMP_LEVEL_RST;
        end else if (ce) begin
            lvl_q <= lvl_d;
        end
    end

    phv_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .push(proc_s),
        .pop(out_s)
    );

    assign out_s.ready = out_ready;
    assign out_valid = out_s.valid;
    assign out_data = out_s.data;
    assign amp_level = lvl_q;
    assign applied_atten = att_q;
    assign path_muted = (att_q == ATT_MUTE);

endmodule // phv_playback_path

// [shared/phv_pkg.sv]
package phv_pkg;

    // ==========================================
    // widths and reset values
    localparam int SAMPLE_W = 16;
    localparam int COEF_W = 32;
    localparam int COEF_FRAC = 30;
    localparam int GAIN_FRAC = 16;
    localparam logic [2:0] CORNER_BYPASS = 3'h0;
    localparam logic [2:0] CORNER_RESERVED = 3'h7;
    localparam logic [2:0] CORNER_RST = 3'h1;
    localparam logic [7:0] VOL_RST = 8'h00;
    localparam logic [7:0] VOL_MAX = 8'hc8;
    localparam logic [7:0] ATT_MUTE = 8'hc9;
    localparam logic [1:0] RAMP_RST = 2'h0;
    localparam logic [1:0] RAMP_EVERY_1 = 2'h0;
    localparam logic [1:0] RAMP_EVERY_4 = 2'h1;
    localparam logic [1:0] RAMP_EVERY_8 = 2'h2;
    localparam logic [1:0] RAMP_OFF = 2'h3;
    localparam logic [3:0] RAMP_PERIOD_1 = 4'h1;
    localparam logic [3:0] RAMP_PERIOD_4 = 4'h4;
    localparam logic [3:0] RAMP_PERIOD_8 = 4'h8;
    localparam logic [4:0] AMP_LEVEL_RST = 5'h10;
    localparam logic [4:0] AMP_LEVEL_MAX = 5'h14;
    localparam logic SRC_PCM = 1'b0;
    localparam logic [7:0] STEPS_PER_OCTAVE = 8'h0c;

    // ==========================================
    // biquad coefficients, signed q2.30
    typedef struct packed {
        logic signed [COEF_W-1:0] b0;
        logic signed [COEF_W-1:0] b1;
        logic signed [COEF_W-1:0] b2;
        logic signed [COEF_W-1:0] a1;
        logic signed [COEF_W-1:0] a2;
    } phv_coef_type;

    // second-order butterworth presets, one per corner code 1 to 6
    function automatic phv_coef_type phv_preset(input logic [2:0] sel);
        logic signed [COEF_W-1:0] b0;
        logic signed [COEF_W-1:0] a1;
        logic signed [COEF_W-1:0] a2;
        phv_coef_type c;
        b0 = 32'sh4000_0000;
        a1 = 32'sh8000_0000;
        a2 = 32'sh4000_0000;
        unique case (sel)
            3'h1: begin b0 = 32'sd1073543000; a1 = -32'sd2147086148; a2 = 32'sd1073344398; end
            3'h2: begin b0 = 32'sd1068784000; a1 = -32'sd2137544948; a2 = 32'sd1063849100; end
            3'h3: begin b0 = 32'sd1063849000; a1 = -32'sd2127606248; a2 = 32'sd1054048900; end
            3'h4: begin b0 = 32'sd1054048000; a1 = -32'sd2107728848; a2 = 32'sd1034723000; end
            3'h5: begin b0 = 32'sd1034723200; a1 = -32'sd2067974048; a2 = 32'sd997177000; end
            3'h6: begin b0 = 32'sd997177000; a1 = -32'sd1988465048; a2 = 32'sd926504000; end
            default: begin b0 = 32'sh4000_0000; a1 = 32'sh0000_0000; a2 = 32'sh0000_0000; end
        endcase
        c.b0 = b0;
        c.b1 = -(b0 <<< 1);
        c.b2 = b0;
        c.a1 = a1;
        c.a2 = a2;
        return c;
    endfunction

    // ==========================================
    // linear gain, unsigned q1.16, from attenuation in 0.5 dB steps
    function automatic logic [GAIN_FRAC:0] phv_gain(input logic [7:0] att);
        logic [GAIN_FRAC:0] m;
        logic [7:0] oct;
        logic [7:0] idx;
        m = 17'h10000;
        oct = att / STEPS_PER_OCTAVE;
        idx = att % STEPS_PER_OCTAVE;
        unique case (idx[3:0])
            4'h0: m = 17'h10000;
            4'h1: m = 17'h0f1ae;
            4'h2: m = 17'h0e429;
            4'h3: m = 17'h0d766;
            4'h4: m = 17'h0cb59;
            4'h5: m = 17'h0bff9;
            4'h6: m = 17'h0b53c;
            4'h7: m = 17'h0ab19;
            4'h8: m = 17'h0a186;
            4'h9: m = 17'h0987d;
            4'ha: m = 17'h08ff6;
            default: m = 17'h087e8;
        endcase
        if (att > VOL_MAX) begin
            return 17'h00000;
        end
        return m >> oct;
    endfunction

endpackage

// [shared/phv_stream_if.sv]
`timescale 1ns/100ps
interface phv_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [tb/phv_host_model.sv]
`timescale 1ns/100ps
module phv_host_model
    import phv_pkg::*;
(
    // clock
    input wire logic clk,
    // stream toward the path
    input wire logic ready,
    output logic valid,
    output logic [SAMPLE_W-1:0] data
);
    initial begin
        valid = 1'b0;
        data = '0;
    end
    // ==========================================
    // hold word until taken, then scramble the idle bus
    task automatic send(input logic [SAMPLE_W-1:0] word);
        logic ok;
        @(negedge clk);
        valid = 1'b1;
        data = word;
        ok = 1'b0;
        while (!ok) begin
            ok = ready;
            @(posedge clk);
            if (!ok) @(negedge clk);
        end
        @(negedge clk);
        valid = 1'b0;
        data = ~word;
    endtask
endmodule // phv_host_model

// [tb/phv_playback_path_props.sv]
`timescale 1ns/100ps
module phv_playback_path_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // streams
    input wire logic pcm_valid,
    input wire logic pcm_ready,
    input wire logic pdm_valid,
    input wire logic pdm_ready,
    // settings
    input wire logic [7:0] pcm_volume_code,
    input wire logic [7:0] pdm_volume_code,
    input wire logic [1:0] ramp_rate_sel,
    input wire logic playback_source_sel,
    input wire logic [4:0] amp_level_code,
    // status
    input wire logic [4:0] amp_level,
    input wire logic [7:0] applied_atten,
    input wire logic path_muted
);
    // ==========================================
    // ramp target of the selected path
    logic [7:0] code;
    logic [7:0] tgt;
    logic take;
    assign code = playback_source_sel ? pdm_volume_code : pcm_volume_code;
    assign tgt = (code > 8'hc8) ? 8'hc9 : code;
    assign take = ce && (playback_source_sel ? (pdm_valid && pdm_ready) : (pcm_valid && pcm_ready));
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_level_follow: assert property (ce && amp_level_code <= 5'h14 |=> amp_level == $past(amp_level_code))
        else $error("level mismatch");
    a_mute_flag: assert property (path_muted == (applied_atten == 8'hc9))
        else $error("mute flag mismatch");
    a_ramp_off: assert property (ce && ramp_rate_sel == 2'h3 |=> applied_atten == $past(tgt))
        else $error("volume not immediate");
    a_step_size: assert property (ramp_rate_sel != 2'h3
        |=> (applied_atten - $past(applied_atten)) inside {8'h00, 8'h01, 8'hff})
        else $error("volume jumped");
    a_no_overshoot: assert property (ramp_rate_sel != 2'h3 && applied_atten <= tgt
        |=> applied_atten <= $past(tgt) && applied_atten >= $past(applied_atten))
        else $error("volume overshoot");
    a_idle_hold: assert property (ramp_rate_sel != 2'h3 && !take |=> $stable(applied_atten))
        else $error("step without sample");
    a_every_sample: assert property (take && ramp_rate_sel == 2'h0 && applied_atten != tgt
        |=> applied_atten != $past(applied_atten))
        else $error("missed step");
    a_source_gate: assert property (playback_source_sel ? !pcm_ready : !pdm_ready)
        else $error("unselected source ready");
    a_ce_freeze: assert property (!ce |=> $stable(applied_atten) && $stable(amp_level))
        else $error("state moved while frozen");
endmodule // phv_playback_path_props

bind phv_playback_path phv_playback_path_props u_props (
    .clk(clk), .reset(reset), .ce(ce), .pcm_valid(pcm_valid), .pcm_ready(pcm_ready),
    .pdm_valid(pdm_valid), .pdm_ready(pdm_ready), .pcm_volume_code(pcm_volume_code),
    .pdm_volume_code(pdm_volume_code), .ramp_rate_sel(ramp_rate_sel),
    .playback_source_sel(playback_source_sel), .amp_level_code(amp_level_code),
    .amp_level(amp_level), .applied_atten(applied_atten), .path_muted(path_muted)
);

// [tb/playback_hpf_volume_path_test.sv]
`timescale 1ns/100ps
module playback_hpf_volume_path_test
    import phv_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic out_ready = 1'b0;
    logic coef_direct_en = 1'b0;
    logic playback_source_sel = 1'b0;
    logic [2:0] highpass_corner_sel = 3'h0;
    logic [1:0] ramp_rate_sel = 2'h3;
    logic [4:0] amp_level_code = 5'h10;
    logic [7:0] pcm_volume_code = 8'h00;
    logic [7:0] pdm_volume_code = 8'h00;
    logic ce = 1'b1;
    logic [31:0] coef_b0 = 32'h0000_0000;
    logic [31:0] coef_b1 = 32'h0000_0000;
    logic [31:0] coef_b2 = 32'h0000_0000;
    logic [31:0] coef_a1 = 32'h0000_0000;
    logic [31:0] coef_a2 = 32'h0000_0000;
    logic pcm_valid, pcm_ready, pdm_valid, pdm_ready, out_valid, path_muted;
    logic [15:0] pcm_data, pdm_data, out_data;
    logic [4:0] amp_level;
    logic [7:0] applied_atten;
    int failures = 0;
    int checked = 0;
    always #2 clk = ~clk;
    phv_playback_path DUT (.clk(clk), .reset(reset), .ce(ce), .pcm_valid(pcm_valid), .pcm_ready(pcm_ready),
        .pcm_data(pcm_data), .pdm_valid(pdm_valid), .pdm_ready(pdm_ready), .pdm_data(pdm_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .highpass_corner_sel(highpass_corner_sel), .coef_direct_en(coef_direct_en), .coef_b0(coef_b0),
        .coef_b1(coef_b1), .coef_b2(coef_b2), .coef_a1(coef_a1), .coef_a2(coef_a2),
        .pcm_volume_code(pcm_volume_code), .pdm_volume_code(pdm_volume_code), .ramp_rate_sel(ramp_rate_sel),
        .playback_source_sel(playback_source_sel), .amp_level_code(amp_level_code), .amp_level(amp_level),
        .applied_atten(applied_atten), .path_muted(path_muted));
    phv_host_model pcm_src (.clk(clk), .ready(pcm_ready), .valid(pcm_valid), .data(pcm_data));
    phv_host_model pdm_src (.clk(clk), .ready(pdm_ready), .valid(pdm_valid), .data(pdm_data));
    // ==========================================
    // shared helpers
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic pop_expect(input logic [15:0] exp);
        int n;
        n = 0;
        while (out_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("out_data", out_data, exp);
        out_ready = 1'b1;
        @(negedge clk);
        out_ready = 1'b0;
        @(negedge clk);
    endtask
    task automatic send_pop(input logic [15:0] word, input logic [15:0] exp);
        pcm_src.send(word);
        pop_expect(exp);
    endtask
    // ==========================================
    // scenarios
    task automatic t_paths;
        send_pop(16'h1234, 16'h1234);
        send_pop(16'h8001, 16'h8001);
        playback_source_sel = 1'b1;
        highpass_corner_sel = 3'h1;
        @(negedge clk);
        check("pcm_ready", 16'(pcm_ready), 16'h0000);
        pdm_src.send(16'h4000);
        pop_expect(16'h4000);
        playback_source_sel = 1'b0;
        highpass_corner_sel = 3'h0;
        coef_direct_en = 1'b1;
        coef_b0 = 32'h2000_0000;
        coef_b1 = 32'h2000_0000;
        send_pop(16'h4000, 16'h2000);
        send_pop(16'h2000, 16'h3000);
        coef_direct_en = 1'b0;
        coef_b1 = 32'h0000_0000;
    endtask
    task automatic t_corner;
        out_ready = 1'b1;
        highpass_corner_sel = 3'h6;
        for (int i = 0; i < 100; i++) pcm_src.send(16'h4000);
        check("hp_dc_small", 16'($signed(out_data) < 256 && $signed(out_data) > -256), 16'h0001);
        highpass_corner_sel = 3'h7;
        pcm_src.send(16'h1234);
        check("out_data", out_data, 16'h1234);
        highpass_corner_sel = 3'h0;
        @(negedge clk);
        out_ready = 1'b0;
    endtask
    task automatic t_mute;
        pcm_volume_code = 8'hd0;
        repeat (2) @(negedge clk);
        check("applied_atten", 16'(applied_atten), 16'h00c9);
        check("path_muted", 16'(path_muted), 16'h0001);
        send_pop(16'h4000, 16'h0000);
        pcm_volume_code = 8'h0c;
        send_pop(16'h4000, 16'h2000);
    endtask
    task automatic t_ramp;
        int per[3] = '{1, 4, 8};
        int n;
        out_ready = 1'b1;
        for (int i = 0; i < 3; i++) begin
            ramp_rate_sel = 2'h3;
            pcm_volume_code = 8'h00;
            repeat (2) @(negedge clk);
            ramp_rate_sel = 2'(i);
            pcm_volume_code = 8'h02;
            n = 0;
            while (applied_atten !== 8'h02 && n < 40) begin
                pcm_src.send(16'h0100);
                n++;
            end
            check("ramp_samples", 16'(n), 16'(2 * per[i]));
        end
        ramp_rate_sel = 2'h3;
        pcm_volume_code = 8'hc6;
        repeat (2) @(negedge clk);
        ramp_rate_sel = 2'h0;
        pcm_volume_code = 8'hff;
        for (int k = 1; k <= 3; k++) begin
            pcm_src.send(16'h0100);
            check("applied_atten", 16'(applied_atten), 16'(8'hc6 + k));
        end
        check("path_muted", 16'(path_muted), 16'h0001);
        ramp_rate_sel = 2'h3;
        pcm_volume_code = 8'h00;
        repeat (12) @(negedge clk);
        out_ready = 1'b0;
    endtask
    task automatic t_level;
        logic [4:0] codes[5] = '{5'h00, 5'h14, 5'h15, 5'h1f, 5'h0a};
        logic [4:0] exps[5] = '{5'h00, 5'h14, 5'h14, 5'h14, 5'h0a};
        for (int i = 0; i < 5; i++) begin
            amp_level_code = codes[i];
            repeat (2) @(negedge clk);
            check("amp_level", 16'(amp_level), 16'(exps[i]));
        end
    endtask
    task automatic t_fifo;
        for (int i = 0; i < 8; i++) pcm_src.send(16'h0a00 + 16'(i));
        check("pcm_ready", 16'(pcm_ready), 16'h0000);
        for (int i = 0; i < 8; i++) pop_expect(16'h0a00 + 16'(i));
        check("out_valid", 16'(out_valid), 16'h0000);
    endtask
    task automatic t_ce;
        pcm_src.send(16'h0777);
        ce = 1'b0;
        out_ready = 1'b1;
        amp_level_code = 5'h03;
        pcm_volume_code = 8'h10;
        repeat (3) @(negedge clk);
        check("amp_level", 16'(amp_level), 16'h000a);
        check("applied_atten", 16'(applied_atten), 16'h0000);
        check("out_valid", 16'(out_valid), 16'h0001);
        ce = 1'b1;
        repeat (2) @(negedge clk);
        check("amp_level", 16'(amp_level), 16'h0003);
        check("applied_atten", 16'(applied_atten), 16'h0010);
        check("out_valid", 16'(out_valid), 16'h0000);
        out_ready = 1'b0;
        pcm_src.send(16'h0555);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        check("amp_level", 16'(amp_level), 16'h0010);
        check("applied_atten", 16'(applied_atten), 16'h0000);
        check("out_valid", 16'(out_valid), 16'h0000);
        check("path_muted", 16'(path_muted), 16'h0000);
        reset = 1'b0;
        @(negedge clk);
        check("amp_level", 16'(amp_level), 16'h0003);
        check("applied_atten", 16'(applied_atten), 16'h0010);
        pcm_volume_code = 8'h00;
        repeat (2) @(negedge clk);
    endtask
    // ==========================================
    // run control
    task automatic finish_test;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check("amp_level", 16'(amp_level), 16'h0010);
        t_paths();
        t_corner();
        t_mute();
        t_ramp();
        t_level();
        t_fifo();
        t_ce();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule // playback_hpf_volume_path_test
